// ---- verilog/plc_regs.svh ----
`ifndef PLC_REGS_SVH
`define PLC_REGS_SVH
// Operation
// - Max speed field RO, resets 5.0 code
// - Max width x2 upstream two-lane, else x1
// - ASPM support RO, reset zero, loadable
// - L0s exit latency RO, resets code three
// - L1 exit latency RO, resets zero
// - Clock PM cap one upstream, zero downstream
// - Data_link_active_state reporting one downstream only
// - Port number equals port index, loadable
// - Surprise down, BW notify reset zero
// - ASPM control selects L0s/L1 entry, reset zero
// - Receiver L0s entry always allowed
// - Completion boundary bit reads zero
// - Link disable downstream only, takes link down
// - Retrain pulses downstream, reads zero
// - Extended sync: 4096 FTS, 1024 TS1
// - Clock PM enable zero holds clkreq low
// - BW interrupt enables writable downstream only
// - Training flag set during training, reset one

// Register byte offsets
`define PLC_OFS_LINK_CAP 8'hcc
`define PLC_OFS_LINK_CTL 8'hd0
// Capability field positions
`define PLC_CAP_SPEED_LSB 0
`define PLC_CAP_WIDTH_LSB 4
`define PLC_CAP_ASPM_LSB 10
`define PLC_CAP_L0S_LSB 12
`define PLC_CAP_L1_LSB 15
`define PLC_CAP_CLKPM_BIT 18
`define PLC_CAP_SDOWN_BIT 19
`define PLC_CAP_DLACT_BIT 20
`define PLC_CAP_BWN_BIT 21
`define PLC_CAP_PORT_LSB 24
// Capability reset values
`define PLC_RST_SPEED 4'h2
`define PLC_RST_WIDTH_X2 6'h02
`define PLC_RST_WIDTH_X1 6'h01
`define PLC_RST_ASPM 2'h0
`define PLC_RST_L0S 3'h3
`define PLC_RST_L1 3'h0
// Control field positions
`define PLC_CTL_ASPM_LSB 0
`define PLC_CTL_RCB_BIT 3
`define PLC_CTL_LDIS_BIT 4
`define PLC_CTL_RETRAIN_BIT 5
`define PLC_CTL_CCLK_BIT 6
`define PLC_CTL_XSYNC_BIT 7
`define PLC_CTL_CLKPM_BIT 8
`define PLC_CTL_HAWD_BIT 9
`define PLC_CTL_BWMIE_BIT 10
`define PLC_CTL_ABWIE_BIT 11
// Training sequence counts
`define PLC_FTS_EXTENDED 13'd4096
`define PLC_TS1_EXTENDED 13'd1024
`endif

// ---- verilog/plc_pkg.sv ----
package plc_pkg;
  // Power-state entry selections
  typedef enum logic [1:0] {
    PLC_ASPM_OFF = 2'h0,
    PLC_ASPM_L0S = 2'h1,
    PLC_ASPM_L1 = 2'h2,
    PLC_ASPM_BOTH = 2'h3
  } plc_aspm_t;
  // Bus slave phases
  typedef enum logic [1:0] {
    PLC_IDLE,
    PLC_WRITE,
    PLC_READ
  } plc_phase_t;
  // Whole block state
  typedef struct packed {
    plc_phase_t phase;
    logic [7:0] addr;
    logic [1:0] cap_aspm;
    logic [2:0] cap_l0s;
    logic [2:0] cap_l1;
    logic cap_clkpm;
    logic cap_sdown;
    logic cap_bwn;
    logic [7:0] cap_port;
    logic [1:0] ctl_aspm;
    logic ctl_ldis;
    logic ctl_cclk;
    logic ctl_xsync;
    logic ctl_clkpm;
    logic ctl_hawd;
    logic ctl_bwmie;
    logic ctl_abwie;
    logic training;
    logic retrain;
    logic [31:0] rdata;
    logic l0s_tx_en;
    logic l1_en;
    logic l0s_rx_en;
    logic link_down;
    logic clkreq_gate_en;
    logic [12:0] fts_cnt;
    logic [12:0] ts1_cnt;
  } plc_state_t;
endpackage

// ---- verilog/plc_link_regs.sv ----
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/100ps
`include "plc_regs.svh"
module plc_link_regs #(
  parameter int PORT_INDEX = 0,
  parameter bit IS_UPSTREAM = 1'b1,
  parameter bit TWO_LANE_UP = 1'b0
) (
  input wire logic CLK_I,
  input wire logic SRST_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  input wire logic LOAD_VALID_I,
  input wire logic [1:0] LOAD_ASPM_I,
  input wire logic [2:0] LOAD_L0S_I,
  input wire logic [2:0] LOAD_L1_I,
  input wire logic LOAD_CLKPM_I,
  input wire logic LOAD_SDOWN_I,
  input wire logic LOAD_BWN_I,
  input wire logic [7:0] LOAD_PORT_I,
  input wire logic TRAINING_DONE_I,
  output logic LINK_DISABLE_O,
  output logic RETRAIN_O,
  output logic L0S_TX_EN_O,
  output logic L0S_RX_EN_O,
  output logic L1_EN_O,
  output logic COMMON_CLOCK_O,
  output logic CLKREQ_GATE_EN_O,
  output logic [12:0] FTS_COUNT_O,
  output logic [12:0] TS1_COUNT_O,
  output logic LINK_TRAINING_O
);
  import plc_pkg::*;

  // Elaboration-time refusal of settings the logic cannot serve
  if (PORT_INDEX < 0 || PORT_INDEX > 5) begin : g_bad_port
    $error("PORT_INDEX must be 0 to 5");
  end
  if (TWO_LANE_UP && !IS_UPSTREAM) begin : g_bad_lanes
    $error("two-lane setting only applies upstream");
  end

  localparam logic [7:0] PORT_RST = 8'(PORT_INDEX);
  localparam logic [5:0] WIDTH_RST = (IS_UPSTREAM && TWO_LANE_UP) ? `PLC_RST_WIDTH_X2 : `PLC_RST_WIDTH_X1;

  plc_state_t st_ff;
  plc_state_t nxt_st;
  logic [31:0] cap_word;
  logic [31:0] ctl_word;
  logic take;

  // Capability word; fixed fields come from straps, reserved bits zero
  always_comb begin
    cap_word = 32'h0;
    cap_word[`PLC_CAP_SPEED_LSB +: 4] = `PLC_RST_SPEED;
    cap_word[`PLC_CAP_WIDTH_LSB +: 6] = WIDTH_RST;
    cap_word[`PLC_CAP_ASPM_LSB +: 2] = st_ff.cap_aspm;
    cap_word[`PLC_CAP_L0S_LSB +: 3] = st_ff.cap_l0s;
    cap_word[`PLC_CAP_L1_LSB +: 3] = st_ff.cap_l1;
    cap_word[`PLC_CAP_CLKPM_BIT] = IS_UPSTREAM ? st_ff.cap_clkpm : 1'b0;
    cap_word[`PLC_CAP_SDOWN_BIT] = st_ff.cap_sdown;
    cap_word[`PLC_CAP_DLACT_BIT] = !IS_UPSTREAM;
    cap_word[`PLC_CAP_BWN_BIT] = st_ff.cap_bwn;
    cap_word[`PLC_CAP_PORT_LSB +: 8] = st_ff.cap_port;
  end

  // Control word; retrain and completion boundary always read zero
  always_comb begin
    ctl_word = 32'h0;
    ctl_word[`PLC_CTL_ASPM_LSB +: 2] = st_ff.ctl_aspm;
    ctl_word[`PLC_CTL_RCB_BIT] = 1'b0;
    ctl_word[`PLC_CTL_LDIS_BIT] = st_ff.ctl_ldis;
    ctl_word[`PLC_CTL_RETRAIN_BIT] = 1'b0;
    ctl_word[`PLC_CTL_CCLK_BIT] = st_ff.ctl_cclk;
    ctl_word[`PLC_CTL_XSYNC_BIT] = st_ff.ctl_xsync;
    ctl_word[`PLC_CTL_CLKPM_BIT] = st_ff.ctl_clkpm;
    ctl_word[`PLC_CTL_HAWD_BIT] = st_ff.ctl_hawd;
    ctl_word[`PLC_CTL_BWMIE_BIT] = st_ff.ctl_bwmie;
    ctl_word[`PLC_CTL_ABWIE_BIT] = st_ff.ctl_abwie;
    ctl_word[27] = st_ff.training; // Link status shares this word
  end

  // Only NONSEQ or SEQ transfers are taken; HSIZE_I is not checked
  assign take = HSEL_I && HREADY_I && HTRANS_I[1];

  // Next-state logic for bus, registers and link-side controls
  always_comb begin
    nxt_st = st_ff;
    nxt_st.retrain = 1'b0;
    // Data phase of a write updates control fields
    if (st_ff.phase == PLC_WRITE && st_ff.addr == `PLC_OFS_LINK_CTL) begin
      nxt_st.ctl_aspm = HWDATA_I[`PLC_CTL_ASPM_LSB +: 2];
      nxt_st.ctl_cclk = HWDATA_I[`PLC_CTL_CCLK_BIT];
      nxt_st.ctl_xsync = HWDATA_I[`PLC_CTL_XSYNC_BIT];
      nxt_st.ctl_hawd = HWDATA_I[`PLC_CTL_HAWD_BIT];
      if (IS_UPSTREAM) begin
        nxt_st.ctl_clkpm = HWDATA_I[`PLC_CTL_CLKPM_BIT];
      end else begin
        nxt_st.ctl_ldis = HWDATA_I[`PLC_CTL_LDIS_BIT];
        nxt_st.retrain = HWDATA_I[`PLC_CTL_RETRAIN_BIT];
        nxt_st.ctl_bwmie = HWDATA_I[`PLC_CTL_BWMIE_BIT];
        nxt_st.ctl_abwie = HWDATA_I[`PLC_CTL_ABWIE_BIT];
      end
    end
    // Sideband loader replaces capability defaults
    if (LOAD_VALID_I) begin
      nxt_st.cap_aspm = LOAD_ASPM_I;
      nxt_st.cap_l0s = LOAD_L0S_I;
      nxt_st.cap_l1 = LOAD_L1_I;
      nxt_st.cap_clkpm = LOAD_CLKPM_I;
      nxt_st.cap_sdown = LOAD_SDOWN_I;
      nxt_st.cap_bwn = LOAD_BWN_I;
      nxt_st.cap_port = LOAD_PORT_I;
    end
    // Retrain request wins over a done in the same cycle
    if (nxt_st.retrain) begin
      nxt_st.training = 1'b1;
    end else if (TRAINING_DONE_I) begin
      nxt_st.training = 1'b0;
    end
    // Address phase capture; reads are answered one cycle later
    nxt_st.phase = PLC_IDLE;
    if (take) begin
      nxt_st.addr = HADDR_I[7:0];
      nxt_st.phase = HWRITE_I ? PLC_WRITE : PLC_READ;
      if (HADDR_I[31:8] != 24'h0) begin
        nxt_st.addr = 8'hff; // Unmapped, reads zero
      end
    end
    nxt_st.rdata = 32'h0;
    if (take && !HWRITE_I) begin
      case (HADDR_I[31:0])
        {24'h0, `PLC_OFS_LINK_CAP}: nxt_st.rdata = cap_word;
        {24'h0, `PLC_OFS_LINK_CTL}: nxt_st.rdata = ctl_word;
        default: nxt_st.rdata = 32'h0;
      endcase
    end
    // Link-side controls derived from the next register values
    nxt_st.l0s_tx_en = nxt_st.ctl_aspm[0];
    nxt_st.l1_en = nxt_st.ctl_aspm[1];
    nxt_st.l0s_rx_en = 1'b1;
    nxt_st.link_down = !IS_UPSTREAM && nxt_st.ctl_ldis;
    nxt_st.clkreq_gate_en = IS_UPSTREAM && nxt_st.ctl_clkpm;
    nxt_st.fts_cnt = nxt_st.ctl_xsync ? `PLC_FTS_EXTENDED : 13'h0;
    nxt_st.ts1_cnt = nxt_st.ctl_xsync ? `PLC_TS1_EXTENDED : 13'h0;
    if (SRST_I) begin
      nxt_st = '0;
      nxt_st.cap_l0s = `PLC_RST_L0S;
      nxt_st.cap_l1 = `PLC_RST_L1;
      nxt_st.cap_aspm = `PLC_RST_ASPM;
      nxt_st.cap_clkpm = IS_UPSTREAM;
      nxt_st.cap_port = PORT_RST;
      nxt_st.training = 1'b1;
      nxt_st.l0s_rx_en = 1'b1;
    end
  end

  // Single state register; reset is folded into the next value
  always_ff @(posedge CLK_I) begin
    st_ff <= nxt_st;
  end

  // Outputs straight from flops; slave is zero wait and always OKAY
  assign HRDATA_O = st_ff.rdata;
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = 1'b0;
  assign LINK_DISABLE_O = st_ff.link_down;
  assign RETRAIN_O = st_ff.retrain;
  assign L0S_TX_EN_O = st_ff.l0s_tx_en;
  assign L0S_RX_EN_O = st_ff.l0s_rx_en;
  assign L1_EN_O = st_ff.l1_en;
  assign COMMON_CLOCK_O = st_ff.ctl_cclk;
  assign CLKREQ_GATE_EN_O = st_ff.clkreq_gate_en;
  assign FTS_COUNT_O = st_ff.fts_cnt;
  assign TS1_COUNT_O = st_ff.ts1_cnt;
  assign LINK_TRAINING_O = st_ff.training;
endmodule

// ---- tb/plc_link_partner.sv ----
`timescale 1ns/100ps
module plc_link_partner (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic training_i,
  input wire logic [3:0] delay_i,
  output logic done_o
);
  logic [3:0] cnt_ff;
  // Done comes delay_i cycles after training starts, so both prompt and slow partners are possible
  always_ff @(posedge clk_i) begin
    if (srst_i || !training_i) cnt_ff <= 4'h0;
    else if (cnt_ff != delay_i) cnt_ff <= cnt_ff + 4'h1;
  end
  assign done_o = training_i && (cnt_ff == delay_i);
endmodule

// ---- tb/plc_link_regs_properties.sv ----
`timescale 1ns/100ps
module plc_link_regs_properties (
  input wire logic CLK_I,
  input wire logic SRST_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  input wire logic [31:0] HRDATA_O,
  input wire logic TRAINING_DONE_I,
  input wire logic LINK_DISABLE_O,
  input wire logic RETRAIN_O,
  input wire logic L0S_TX_EN_O,
  input wire logic L0S_RX_EN_O,
  input wire logic L1_EN_O,
  input wire logic COMMON_CLOCK_O,
  input wire logic [12:0] FTS_COUNT_O,
  input wire logic [12:0] TS1_COUNT_O,
  input wire logic LINK_TRAINING_O
);
  logic wr_ctl_ff;
  logic rd_ctl_ff;
  logic rd_cap_ff;
  wire take = HSEL_I && HREADY_I && HTRANS_I[1];
  // Data phase markers; full address decode, as in the slave
  always_ff @(posedge CLK_I) begin
    wr_ctl_ff <= !SRST_I && take && HWRITE_I && (HADDR_I == 32'hd0);
    rd_ctl_ff <= !SRST_I && take && !HWRITE_I && (HADDR_I == 32'hd0);
    rd_cap_ff <= !SRST_I && take && !HWRITE_I && (HADDR_I == 32'hcc);
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  rx_l0s_a: assert property (L0S_RX_EN_O) else $error("receiver L0s entry blocked");
  retrain_pulse_a: assert property (RETRAIN_O |=> !RETRAIN_O) else $error("retrain longer than one cycle");
  retrain_flag_a: assert property (RETRAIN_O |-> LINK_TRAINING_O) else $error("retrain without flag");
  train_clear_a: assert property (LINK_TRAINING_O && TRAINING_DONE_I && !wr_ctl_ff |=> !LINK_TRAINING_O)
    else $error("training flag not cleared");
  aspm_follow_a: assert property (wr_ctl_ff |=> L0S_TX_EN_O == $past(HWDATA_I[0]) && L1_EN_O == $past(HWDATA_I[1]))
    else $error("entry enables wrong");
  cclk_follow_a: assert property (wr_ctl_ff |=> COMMON_CLOCK_O == $past(HWDATA_I[6])) else $error("common clock");
  xsync_count_a: assert property (wr_ctl_ff |=> FTS_COUNT_O == ($past(HWDATA_I[7]) ? 13'd4096 : 13'd0)
    && TS1_COUNT_O == ($past(HWDATA_I[7]) ? 13'd1024 : 13'd0)) else $error("sequence counts wrong");
  ldis_cause_a: assert property ($rose(LINK_DISABLE_O) |-> $past(wr_ctl_ff) && $past(HWDATA_I[4]))
    else $error("link disable without write");
  ctl_zero_a: assert property (rd_ctl_ff |-> HRDATA_O[15:12] == 4'h0 && HRDATA_O[3:2] == 2'h0 && !HRDATA_O[5]
    && HRDATA_O[26:16] == 11'h0 && HRDATA_O[31:28] == 4'h0) else $error("control zero bits set");
  cap_speed_a: assert property (rd_cap_ff |-> HRDATA_O[3:0] == 4'h2 && HRDATA_O[23:22] == 2'h0)
    else $error("speed or reserved wrong");
  idle_zero_a: assert property (!rd_ctl_ff && !rd_cap_ff |-> HRDATA_O == 32'h0) else $error("read data stray");
  cover property (wr_ctl_ff && HWDATA_I[5]);
  cover property (LINK_DISABLE_O && FTS_COUNT_O != 13'd0);
  cover property (rd_cap_ff);
endmodule
bind plc_link_regs plc_link_regs_properties u_props (.*);

// ---- tb/plc_link_regs_bench.sv ----
`timescale 1ns/100ps
module plc_link_regs_bench;
  import plc_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  logic [31:0] hrdata;
  logic [31:0] hrdata_up;
  logic [31:0] rdu;
  logic done_up, ldis_up, retr_up, gate_up, lt_up;
  logic hready;
  logic load = 1'b0;
  logic [18:0] ldv = 19'h0;
  logic [3:0] dly = 4'hf;
  logic done, ldis, retr, l0stx, l0srx, l1, cclk, gate, lt;
  logic [12:0] fts, ts1;
  int err_count = 0;
  int n_checks = 0;
  always #50 clk = ~clk;
  plc_link_regs #(.PORT_INDEX(3), .IS_UPSTREAM(1'b0)) DUT (.CLK_I(clk), .SRST_I(srst), .HSEL_I(1'b1),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(), .LOAD_VALID_I(load), .LOAD_ASPM_I(ldv[1:0]),
    .LOAD_L0S_I(ldv[4:2]), .LOAD_L1_I(ldv[7:5]), .LOAD_CLKPM_I(ldv[8]), .LOAD_SDOWN_I(ldv[9]),
    .LOAD_BWN_I(ldv[10]), .LOAD_PORT_I(ldv[18:11]), .TRAINING_DONE_I(done), .LINK_DISABLE_O(ldis),
    .RETRAIN_O(retr), .L0S_TX_EN_O(l0stx), .L0S_RX_EN_O(l0srx), .L1_EN_O(l1), .COMMON_CLOCK_O(cclk),
    .CLKREQ_GATE_EN_O(gate), .FTS_COUNT_O(fts), .TS1_COUNT_O(ts1), .LINK_TRAINING_O(lt));
  plc_link_partner PART (.clk_i(clk), .srst_i(srst), .training_i(lt), .delay_i(dly), .done_o(done));
  // Upstream two-lane port on the same bus, so the upstream-only fixings are exercised
  plc_link_regs #(.PORT_INDEX(0), .IS_UPSTREAM(1'b1), .TWO_LANE_UP(1'b1)) DUT_UP (.CLK_I(clk), .SRST_I(srst),
    .HSEL_I(1'b1), .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
    .HREADY_I(hready), .HRDATA_O(hrdata_up), .HREADYOUT_O(), .HRESP_O(), .LOAD_VALID_I(load),
    .LOAD_ASPM_I(ldv[1:0]), .LOAD_L0S_I(ldv[4:2]), .LOAD_L1_I(ldv[7:5]), .LOAD_CLKPM_I(ldv[8]),
    .LOAD_SDOWN_I(ldv[9]), .LOAD_BWN_I(ldv[10]), .LOAD_PORT_I(ldv[18:11]), .TRAINING_DONE_I(done_up),
    .LINK_DISABLE_O(ldis_up), .RETRAIN_O(retr_up), .L0S_TX_EN_O(), .L0S_RX_EN_O(), .L1_EN_O(),
    .COMMON_CLOCK_O(), .CLKREQ_GATE_EN_O(gate_up), .FTS_COUNT_O(), .TS1_COUNT_O(), .LINK_TRAINING_O(lt_up));
  plc_link_partner PART_UP (.clk_i(clk), .srst_i(srst), .training_i(lt_up), .delay_i(dly), .done_o(done_up));
  // One single transfer; waits on ready, read data taken at the data phase edge
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
    rdu = hrdata_up;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, s, e);
    end
  endtask
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Whole run is about 70 cycles; the limit of 1000 cycles is generous
  initial begin
    #100000;
    err_count++;
    complete_run();
  end
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    bus(1'b0, 32'hcc, 32'h0, rd);
    chk(rd, 32'h03103012);
    chk(rdu, 32'h00043022);
    bus(1'b0, 32'hd0, 32'h0, rd);
    chk(rd, 32'h08000000);
    chk(rdu, 32'h08000000);
    repeat (20) @(posedge clk);
    chk(lt, 32'h0);
    chk(lt_up, 32'h0);
    $display("Test reset values done");
    bus(1'b1, 32'hd0, 32'hffffffff, rd);
    @(negedge clk);
    chk(retr, 32'h1);
    chk({ldis, l0stx, l1, cclk, gate, l0srx}, 6'b111101);
    chk({fts, ts1}, {13'd4096, 13'd1024});
    chk({ldis_up, retr_up, gate_up}, 3'b001);
    @(negedge clk);
    chk(retr, 32'h0);
    bus(1'b0, 32'hd0, 32'h0, rd);
    chk(rd, 32'h08000ed3);
    chk(rdu, 32'h000003c3);
    $display("Test control write done");
    dly <= 4'h1;
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, 32'hd0, c, rd);
      @(negedge clk);
      chk({l0stx, l1, l0srx, ldis, cclk, fts}, {c[0], c[1], 1'b1, 1'b0, 1'b0, 13'd0});
      chk(gate_up, 32'h0);
    end
    $display("Test entry codes done");
    bus(1'b1, 32'hcc, 32'hffffffff, rd);
    bus(1'b0, 32'hcc, 32'h0, rd);
    chk(rd, 32'h03103012);
    chk(rdu, 32'h00043022);
    bus(1'b0, 32'h40, 32'h0, rd);
    chk(rd, 32'h0);
    chk(rdu, 32'h0);
    $display("Test read-only and unmapped done");
    dly <= 4'hf;
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    bus(1'b0, 32'hd0, 32'h0, rd);
    chk(rd, 32'h08000000);
    chk(rdu, 32'h08000000);
    $display("Test mid-run reset done");
    @(posedge clk);
    ldv <= 19'h157d7;
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
    bus(1'b0, 32'hcc, 32'h0, rd);
    chk(rd, 32'h2a3b5c12);
    chk(rdu, 32'h2a2f5c22);
    $display("Test loader done");
    complete_run();
  end
endmodule
